// *** hdl/dgc_map.svh ***
// Register offsets, field positions and reset values of the DMA global control block.
// Included by the package users; holds definitions only.
`ifndef DGC_MAP_SVH
`define DGC_MAP_SVH
`define DGC_OFF_CTRL 16'h3000
`define DGC_OFF_SPTR 16'h3310
`define DGC_OFF_DPTR 16'h3320
`define DGC_OFF_CSIZ 16'h3330
`define DGC_OFF_CPTR 16'h3340
`define DGC_OFF_PDAT 16'h3350
`define DGC_ALIAS_CLR 2'h1
`define DGC_ALIAS_SET 2'h2
`define DGC_ALIAS_INV 2'h3
`define DGC_BIT_ON 15
`define DGC_BIT_SUSP 12
`define DGC_BIT_BUSY 11
`define DGC_RST_WORD 32'h0000_0000
`define DGC_PDAT_W 8
`define DGC_FIELD_W 16
`endif

// *** hdl/dgc_pkg.sv ***
// Types shared by the DMA global control block.
// No assumptions beyond a SystemVerilog tool.
package dgc_pkg;
  typedef enum logic [2:0]
  {
    DGC_OFF = 3'b001,
    DGC_RUN = 3'b010,
    DGC_HOLD = 3'b100
  } dgc_state_t;
  typedef enum logic [1:0]
  {
    DGC_WR_PLAIN = 2'h0,
    DGC_WR_CLR = 2'h1,
    DGC_WR_SET = 2'h2,
    DGC_WR_INV = 2'h3
  } dgc_wop_t;
endpackage

// *** hdl/dgc_alias_reg.sv ***
// One software register with plain, clear, set and invert writes plus a hardware load.
// Assumes the caller decodes the address and the alias kind.
`timescale 1ns/10ps
module dgc_alias_reg #(
  parameter int W = 16
) (
  input wire logic i_mclk, // Clock.
  input wire logic i_resetn, // Async reset, active low.
  input wire logic i_we, // Software write strobe.
  input wire dgc_pkg::dgc_wop_t i_op, // Write kind.
  input wire logic [W-1:0] i_wdata, // Software write data.
  input wire logic i_hw_ld, // Hardware load strobe.
  input wire logic [W-1:0] i_hw_val, // Hardware load value.
  output logic [W-1:0] o_val // Register value.
);
  import dgc_pkg::*;
  // A register without storage bits cannot serve any field.
  if (W < 1)
  begin : g_w_check
    $error("dgc_alias_reg needs W of at least one");
  end
  logic [W-1:0] val_q;
  logic [W-1:0] val_d;
  always_comb
  begin
    val_d = val_q;
    if (i_hw_ld)
    begin
      val_d = i_hw_val;
    end
    else if (i_we)
    begin
      unique case (i_op)
        DGC_WR_PLAIN: val_d = i_wdata;
        DGC_WR_CLR: val_d = val_q & ~i_wdata;
        DGC_WR_SET: val_d = val_q | i_wdata;
        DGC_WR_INV: val_d = val_q ^ i_wdata;
      endcase
    end
  end
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      val_q <= '0;
    end
    else
    begin
      val_q <= val_d;
    end
  end
  assign o_val = val_q;
endmodule

// *** hdl/dgc_top.sv ***
// DMA global control and channel 3 pointer, cell-size and pattern-data registers.
// Assumes an Avalon-MM master and a channel sequencer that requests pointer steps.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
`include "dgc_map.svh"
module dgc_top (
  input wire logic i_mclk, // Clock, 100 MHz.
  input wire logic i_resetn, // Async reset, active low.
  input wire logic [15:0] i_address, // Avalon byte address.
  input wire logic i_read, // Avalon read.
  input wire logic i_write, // Avalon write.
  input wire logic [31:0] i_writedata, // Avalon write data.
  input wire logic [3:0] i_byteenable, // Avalon byte enables.
  output logic [31:0] o_readdata, // Avalon read data.
  output logic o_waitrequest, // Avalon wait.
  output logic [1:0] o_response, // Avalon response, 2 is slave error.
  input wire logic i_xfer_req, // Channel 3 transfer request level.
  input wire logic i_step_done, // Sequencer finished one cell step.
  output logic o_xfer_grant, // Transfers may proceed this cycle.
  output dgc_pkg::dgc_state_t o_state // Engine state.
);
  import dgc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] resp_q;
  logic [1:0] resp_d;
  logic on_q;
  logic on_d;
  logic susp_q;
  logic susp_d;
  logic pend_q;
  logic pend_d;
  dgc_state_t st_q;
  dgc_state_t st_d;
  logic [15:0] base;
  dgc_wop_t op;
  logic hit_ctrl;
  logic hit_sptr;
  logic hit_dptr;
  logic hit_csiz;
  logic hit_cptr;
  logic hit_pdat;
  logic hit_any;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic [15:0] sptr;
  logic [15:0] dptr;
  logic [15:0] csiz;
  logic [15:0] cptr;
  logic [7:0] pdat;
  logic step;
  logic busy;
  // Each request gets one wait cycle; the answer lands on the second edge.
  assign base = {i_address[15:4], 4'h0};
  assign op = dgc_wop_t'(i_address[3:2]);
  assign hit_ctrl = (base == `DGC_OFF_CTRL);
  assign hit_sptr = (base == `DGC_OFF_SPTR);
  assign hit_dptr = (base == `DGC_OFF_DPTR);
  assign hit_csiz = (base == `DGC_OFF_CSIZ);
  assign hit_cptr = (base == `DGC_OFF_CPTR);
  assign hit_pdat = (base == `DGC_OFF_PDAT);
  assign hit_any = hit_ctrl | hit_sptr | hit_dptr | hit_csiz | hit_cptr | hit_pdat;
  // A write lands at the edge that ends the wait, when the master sees waitrequest low.
  assign wr_go = i_write & ack_q;
  assign wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                  {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  // Byte enables narrow wd; a plain write drives wd to zero, and csiz and pdat keep disabled bytes themselves.
  always_comb
  begin
    wd = i_writedata & wmask;
    if (op == DGC_WR_PLAIN)
    begin
      wd = 32'h0000_0000;
    end
  end
  function automatic logic apply(input logic cur, input logic b, input logic m, input dgc_wop_t o);
    logic r;
    r = cur;
    if (m)
    begin
      unique case (o)
        DGC_WR_PLAIN: r = b;
        DGC_WR_CLR: r = cur & ~b;
        DGC_WR_SET: r = cur | b;
        DGC_WR_INV: r = cur ^ b;
      endcase
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Only bits 15 and 12 have storage; the rest of the control word is dropped.
  always_comb
  begin
    on_d = on_q;
    susp_d = susp_q;
    if (wr_go && hit_ctrl)
    begin
      on_d = apply(on_q, i_writedata[`DGC_BIT_ON], i_byteenable[1], op);
      susp_d = apply(susp_q, i_writedata[`DGC_BIT_SUSP], i_byteenable[1], op);
    end
  end
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      on_q <= 1'b0;
      susp_q <= 1'b0;
    end
    else
    begin
      on_q <= on_d;
      susp_q <= susp_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Engine state: pending request survives a suspend and resumes afterwards.
  always_comb
  begin
    st_d = st_q;
    pend_d = pend_q;
    if (i_xfer_req)
    begin
      pend_d = 1'b1;
    end
    else if (step)
    begin
      pend_d = 1'b0;
    end
    unique case (st_q)
      DGC_OFF:
      begin
        pend_d = 1'b0;
        if (on_q)
        begin
          st_d = susp_q ? DGC_HOLD : DGC_RUN;
        end
      end
      DGC_RUN:
      begin
        if (!on_q)
        begin
          st_d = DGC_OFF;
        end
        else if (susp_q)
        begin
          st_d = DGC_HOLD;
        end
      end
      DGC_HOLD:
      begin
        if (!on_q)
        begin
          st_d = DGC_OFF;
        end
        else if (!susp_q)
        begin
          st_d = DGC_RUN;
        end
      end
      default: st_d = DGC_OFF;
    endcase
  end
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q <= DGC_OFF;
      pend_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      pend_q <= pend_d;
    end
  end
  assign o_xfer_grant = (st_q == DGC_RUN) && on_q && !susp_q && pend_q;
  assign step = o_xfer_grant & i_step_done;
  assign busy = (st_q != DGC_OFF) || pend_q;
  assign o_state = st_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Pointers are read-only to software and step only on granted cells, so they freeze
  // while suspended.
  dgc_alias_reg #(.W(`DGC_FIELD_W)) u_sptr (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_we(1'b0), .i_op(op), .i_wdata(wd[15:0]), .i_hw_ld(step),
    .i_hw_val(16'(sptr + 16'h0001)), .o_val(sptr));
  dgc_alias_reg #(.W(`DGC_FIELD_W)) u_dptr (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_we(1'b0), .i_op(op), .i_wdata(wd[15:0]), .i_hw_ld(step),
    .i_hw_val(16'(dptr + 16'h0001)), .o_val(dptr));
  dgc_alias_reg #(.W(`DGC_FIELD_W)) u_cptr (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_we(1'b0), .i_op(op), .i_wdata(wd[15:0]), .i_hw_ld(step),
    .i_hw_val(16'(cptr + 16'h0001)), .o_val(cptr));
  dgc_alias_reg #(.W(`DGC_FIELD_W)) u_csiz (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_we(wr_go && hit_csiz), .i_op(op),
    .i_wdata((op == DGC_WR_PLAIN) ? ((i_writedata[15:0] & wmask[15:0]) |
      (csiz & ~wmask[15:0])) : (i_writedata[15:0] & wmask[15:0])),
    .i_hw_ld(1'b0), .i_hw_val(16'h0000), .o_val(csiz));
  dgc_alias_reg #(.W(`DGC_PDAT_W)) u_pdat (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_we(wr_go && hit_pdat), .i_op(op),
    .i_wdata((op == DGC_WR_PLAIN && !i_byteenable[0]) ? pdat :
      (i_writedata[7:0] & wmask[7:0])),
    .i_hw_ld(1'b0), .i_hw_val(8'h00), .o_val(pdat));
  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer; alias addresses read back the base register.
  always_comb
  begin
    ack_d = (i_read | i_write) & ~ack_q;
    rdata_d = rdata_q;
    resp_d = resp_q;
    if ((i_read | i_write) && !ack_q)
    begin
      rdata_d = `DGC_RST_WORD;
      resp_d = hit_any ? 2'h0 : 2'h2;
      if (i_read)
      begin
        if (hit_ctrl)
        begin
          rdata_d[`DGC_BIT_ON] = on_q;
          rdata_d[`DGC_BIT_SUSP] = susp_q;
          rdata_d[`DGC_BIT_BUSY] = busy;
        end
        if (hit_sptr) rdata_d[15:0] = sptr;
        if (hit_dptr) rdata_d[15:0] = dptr;
        if (hit_csiz) rdata_d[15:0] = csiz;
        if (hit_cptr) rdata_d[15:0] = cptr;
        if (hit_pdat) rdata_d[7:0] = pdat;
      end
    end
  end
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ack_q <= 1'b0;
      rdata_q <= `DGC_RST_WORD;
      resp_q <= 2'h0;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      resp_q <= resp_d;
    end
  end
  assign o_waitrequest = (i_read | i_write) & ~ack_q;
  assign o_readdata = rdata_q;
  assign o_response = resp_q;
  ////////////////////////////////////////////////////////////////////////////////
  grant_off_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !on_q |-> !o_xfer_grant) else $error("grant while disabled");
  grant_susp_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    susp_q |-> !o_xfer_grant) else $error("grant while suspended");
  susp_hold_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    susp_q && $past(susp_q) |-> $stable(sptr) && $stable(cptr)) else
    $error("pointer moved in suspend");
  busy_off_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    on_q && !$past(on_q) |=> busy) else $error("busy low after enable");
  ctrl_zero_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    ack_q && $past(i_read && hit_ctrl) |->
    (o_readdata & 32'hffff_67ff) == 32'h0000_0000) else
    $error("unimplemented control bit set");
  set_alias_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_go && hit_csiz && op == DGC_WR_SET && i_byteenable == 4'hf |=>
    csiz == ($past(csiz) | $past(i_writedata[15:0]))) else
    $error("set alias wrong");
  clr_alias_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_go && hit_ctrl && op == DGC_WR_CLR && i_writedata[`DGC_BIT_ON] && i_byteenable[1] |=>
    !on_q) else $error("clear alias failed");
  one_wait_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_read && !ack_q |=> ack_q && !o_waitrequest) else $error("answer late");
endmodule

// *** test/dgc_seq_model.sv ***
// Behavioural channel sequencer facing the grant side of the control block.
// Assumes one clock shared with the block and the bench.
`timescale 1ns/10ps
module dgc_seq_model (
  input wire logic i_mclk, // Clock.
  input wire logic i_resetn, // Async reset, active low.
  input wire logic i_en, // Bench lets the sequencer request.
  input wire logic i_grant, // Grant from the block.
  output logic o_req, // Transfer request level.
  output logic o_step, // One cell finished.
  output logic [15:0] o_count // Cells finished while granted.
);
  assign o_req = i_en;
  // A step every other granted cycle, so the block never sees steps back to back.
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_step <= 1'b0;
      o_count <= 16'h0;
    end
    else
    begin
      if (o_step && i_grant)
        o_count <= o_count + 16'h1;
      o_step <= i_grant && i_en && !o_step;
    end
  end
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the control block over Avalon-MM.
// Assumes the register map header and the sequencer model.
`timescale 1ns/10ps
`include "dgc_map.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
  import dgc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic seq_en = 1'b0;
  logic [15:0] i_address = 16'h0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0] i_byteenable = 4'hf;
  logic [31:0] o_readdata, rd;
  logic o_waitrequest, o_xfer_grant, i_xfer_req, i_step_done;
  logic [1:0] o_response, rs;
  logic [15:0] cnt, snap;
  dgc_state_t o_state;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [15:0] offs [6] = '{`DGC_OFF_CTRL, `DGC_OFF_SPTR, `DGC_OFF_DPTR,
    `DGC_OFF_CSIZ, `DGC_OFF_CPTR, `DGC_OFF_PDAT};
  always #5 i_mclk = ~i_mclk;
  dgc_top uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_response(o_response), .i_xfer_req(i_xfer_req), .i_step_done(i_step_done),
    .o_xfer_grant(o_xfer_grant), .o_state(o_state));
  dgc_seq_model seq (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_en(seq_en),
    .i_grant(o_xfer_grant), .o_req(i_xfer_req), .o_step(i_step_done), .o_count(cnt));
  ////////////////////////////////////////////////////////////////////////////////
  task complete_run;
  begin
    $display("counts: %0d checks, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // The request stands until a rising edge sees waitrequest low; the answer is taken there.
  // Only the cycle ceiling below ends a wait that never finishes.
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
  begin
    @(posedge i_mclk);
    i_write <= w;
    i_read <= ~w;
    i_address <= a;
    i_writedata <= d;
    @(posedge i_mclk);
    while (o_waitrequest !== 1'b0)
      @(posedge i_mclk);
    rd = o_readdata;
    rs = o_response;
    i_write <= 1'b0;
    i_read <= 1'b0;
  end
  endtask
  task rdchk(input string n, input logic [15:0] a, input logic [31:0] e);
  begin
    acc(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  end
  endtask
  task idle(input int k);
  begin
    repeat (k) @(negedge i_mclk);
  end
  endtask
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_resetn <= 1'b1;
    for (int k = 0; k < 6; k++)
      rdchk("reset", offs[k], 32'h0);
    `CHK("state", DGC_OFF, o_state)
    $display("test reset done");
    acc(1'b1, `DGC_OFF_CSIZ, 32'hffff_ffff);
    `CHK("write resp", 2'h0, rs)
    rdchk("csiz", `DGC_OFF_CSIZ, 32'h0000_ffff);
    acc(1'b1, `DGC_OFF_CSIZ + 16'h4, 32'h0000_00f0);
    rdchk("csiz clr", `DGC_OFF_CSIZ, 32'h0000_ff0f);
    acc(1'b1, `DGC_OFF_CSIZ + 16'hc, 32'h0000_0f0f);
    rdchk("csiz inv", `DGC_OFF_CSIZ, 32'h0000_f000);
    acc(1'b1, `DGC_OFF_CSIZ + 16'h8, 32'h0000_0003);
    rdchk("csiz set", `DGC_OFF_CSIZ, 32'h0000_f003);
    i_byteenable <= 4'h1;
    acc(1'b1, `DGC_OFF_CSIZ, 32'h0000_1234);
    i_byteenable <= 4'hf;
    rdchk("csiz lane", `DGC_OFF_CSIZ, 32'h0000_f034);
    acc(1'b1, `DGC_OFF_PDAT, 32'hffff_ffff);
    acc(1'b1, `DGC_OFF_PDAT + 16'h4, 32'h0000_000f);
    acc(1'b1, `DGC_OFF_PDAT + 16'hc, 32'h0000_003c);
    rdchk("pdat", `DGC_OFF_PDAT, 32'h0000_00cc);
    acc(1'b1, `DGC_OFF_SPTR, 32'h0000_1234);
    rdchk("sptr ro", `DGC_OFF_SPTR, 32'h0);
    acc(1'b0, 16'h3100, 32'h0);
    `CHK("unmapped resp", 2'h2, rs)
    `CHK("unmapped data", 32'h0, rd)
    $display("test registers done");
    acc(1'b1, `DGC_OFF_CTRL, 32'hffff_ffff);
    rdchk("ctrl all", `DGC_OFF_CTRL, 32'h0000_9800);
    acc(1'b1, `DGC_OFF_CTRL + 16'h4, 32'hffff_ffff);
    idle(2);
    rdchk("ctrl off", `DGC_OFF_CTRL, 32'h0);
    $display("test control done");
    @(posedge i_mclk);
    seq_en <= 1'b1;
    idle(10);
    `CHK("grant off", 1'b0, o_xfer_grant)
    `CHK("no steps", 16'h0, cnt)
    acc(1'b1, `DGC_OFF_CTRL + 16'h8, 32'h0000_8000);
    idle(30);
    `CHK("run", DGC_RUN, o_state)
    rdchk("ctrl busy", `DGC_OFF_CTRL, 32'h0000_8800);
    acc(1'b1, `DGC_OFF_CTRL + 16'h8, 32'h0000_1000);
    idle(3);
    snap = cnt;
    idle(20);
    `CHK("ran", 1'b1, snap != 16'h0)
    `CHK("grant held", 1'b0, o_xfer_grant)
    `CHK("hold", DGC_HOLD, o_state)
    `CHK("steps held", snap, cnt)
    rdchk("sptr held", `DGC_OFF_SPTR, {16'h0, snap});
    acc(1'b1, `DGC_OFF_CTRL + 16'h4, 32'h0000_1000);
    idle(20);
    `CHK("resumed", 1'b1, cnt > snap)
    @(posedge i_mclk);
    seq_en <= 1'b0;
    idle(5);
    rdchk("sptr", `DGC_OFF_SPTR, {16'h0, cnt});
    rdchk("dptr", `DGC_OFF_DPTR, {16'h0, cnt});
    rdchk("cptr", `DGC_OFF_CPTR, {16'h0, cnt});
    acc(1'b1, `DGC_OFF_CTRL + 16'h4, 32'h0000_8000);
    idle(2);
    rdchk("ctrl idle", `DGC_OFF_CTRL, 32'h0);
    `CHK("off", DGC_OFF, o_state)
    `CHK("grant end", 1'b0, o_xfer_grant)
    $display("test transfers done");
    complete_run;
  end
endmodule
